// File: dwp_pkg.sv
// package for the dual watchdog pair: register map, keys, reset values and state layout
package dwp_pkg;

  // register byte offsets on the avalon slave
  localparam int unsigned ADDR_W        = 5;
  localparam logic [4:0]  OFF_KEY       = 5'h00;
  localparam logic [4:0]  OFF_PSC       = 5'h04;
  localparam logic [4:0]  OFF_RLD       = 5'h08;
  localparam logic [4:0]  OFF_IWSTS     = 5'h0c;
  localparam logic [4:0]  OFF_WCTRL     = 5'h10;
  localparam logic [4:0]  OFF_WCFG      = 5'h14;
  localparam logic [4:0]  OFF_WSTS      = 5'h18;
  localparam logic [4:0]  OFF_DBG       = 5'h1c;

  // key command values
  localparam logic [15:0] KEY_UNLOCK    = 16'h5555;
  localparam logic [15:0] KEY_RELOAD    = 16'haaaa;
  localparam logic [15:0] KEY_START     = 16'hcccc;

  // field positions
  localparam int unsigned WCTRL_EN_BIT  = 7;
  localparam int unsigned WCFG_TB_LSB   = 7;
  localparam int unsigned WCFG_EWI_BIT  = 9;

  // values after reset and thresholds
  localparam logic [2:0]  PSC_RST       = 3'h0;
  localparam logic [11:0] RLD_RST       = 12'hfff;
  localparam logic [6:0]  WCNT_RST      = 7'h7f;
  localparam logic [6:0]  WWIN_RST      = 7'h7f;
  localparam logic [6:0]  WCNT_WARN     = 7'h40;
  localparam logic [6:0]  WCNT_PREWARN  = 7'h41;
  localparam logic [2:0]  PSC_MAX_CODE  = 3'h6;
  localparam logic [7:0]  IW_DIV_BASE   = 8'h04;
  localparam logic [7:0]  IW_DIV_TOP    = 8'hff;

  // avalon-mm request from the master
  typedef struct packed {
    logic              read;
    logic              write;
    logic [ADDR_W-1:0] address;
    logic [31:0]       writedata;
    logic [3:0]        byteenable;
  } dwp_avreq_s;

  // whole state of the block
  typedef struct packed {
    logic        busAck;
    logic [31:0] rdData;
    logic        sysRst;
    logic        hwCaught;
    logic        unlocked;
    logic        iwRun;
    logic [2:0]  pscSel;
    logic [2:0]  pscAct;
    logic        pscPend;
    logic [11:0] rldSel;
    logic [11:0] rldAct;
    logic        rldPend;
    logic [7:0]  iwPre;
    logic [11:0] iwCnt;
    logic        dbgFreeze;
    logic        wwEn;
    logic [6:0]  wwCnt;
    logic [6:0]  wwWin;
    logic [1:0]  wwTb;
    logic        early_warning_irq_enable;
    logic        ewFlag;
    logic [2:0]  wwPre;
  } dwp_state_s;

endpackage : dwp_pkg

// File: dwp_watchdog.sv
// dual watchdog pair: independent watchdog and window watchdog behind an avalon-mm slave
// Function
// - start key runs counter, reset at zero
// - reload key copies reload value into counter
// - unlock key needed before prescaler/reload writes
// - any other key restores write protection
// - reload key also restores write protection
// - hardware option starts watchdog after reset
// - debug halt freezes counter when configured
// - twelve-bit counter and reload, prescaled clock
// - independent watchdog runs on its own tick
// - keeps counting in low-power states
// - seven-bit window counter, bus clock prescaled
// - enabled window resets on 0x40 to 0x3f
// - refresh above window value causes reset
// - window watchdog disabled after reset
// - window counter runs even when disabled
// - early warning flag set at 0x40
// - early warning flag cleared by writing zero
// - window timeout is 2^tb times count
// - prescaler code selects divide 4 to 256
// - prescaler pending flag high during transfer
// - reload pending flag high during transfer
// - key reads zero, reload resets all ones
`timescale 1ns/1ps
module dwp_watchdog (
  // clock and reset
  input  wire logic                mclk,
  input  wire logic                nrst,
  // avalon-mm slave
  input  wire dwp_pkg::dwp_avreq_s avsReq,
  output logic                     avsWaitrequest,
  output logic [31:0]              avsReaddata,
  // watchdog environment
  input  wire logic                lsiTick,
  input  wire logic                hwWdgOpt,
  input  wire logic                debugHalt,
  // results
  output logic                     sysResetReq,
  output logic                     earlyWarnIrq
);

  dwp_pkg::dwp_state_s st_q;
  dwp_pkg::dwp_state_s st_d;

  logic        rstMeta_q;
  logic        rstN;
  logic        wrAcc;
  logic        keyWr;
  logic [15:0] keyVal;
  logic        pscWr;
  logic        rldWr;
  logic        ctrlWr;
  logic        cfgWr;
  logic        stsWr;
  logic        dbgWr;
  logic        iwFrozen;
  logic        iwTick;
  logic        iwPreWrap;
  logic        iwStep;
  logic        iwLoad;
  logic        wwStep;

  // address match, used by every register strobe
  function automatic logic isReg(input logic [dwp_pkg::ADDR_W-1:0] a,
                                 input logic [dwp_pkg::ADDR_W-1:0] off);
    isReg = (a == off);
  endfunction : isReg

  // last prescaler count for a divider code; codes above the top also divide by 256
  function automatic logic [7:0] iwDivLast(input logic [2:0] code);
    if (code >= dwp_pkg::PSC_MAX_CODE) begin
      iwDivLast = dwp_pkg::IW_DIV_TOP;
    end else begin
      iwDivLast = 8'((dwp_pkg::IW_DIV_BASE << code) - 8'h01);
    end
  endfunction : iwDivLast

  // reset release through two flops; only the second flop is read
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstMeta_q <= 1'b0;
      rstN      <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstN      <= rstMeta_q;
    end
  end

  // write strobes; a write with byteenable[1:0] set lands on the edge where waitrequest is low
  assign wrAcc  = avsReq.write & st_q.busAck & (avsReq.byteenable[1:0] == 2'b11);
  assign keyWr  = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_KEY);
  assign pscWr  = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_PSC);
  assign rldWr  = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_RLD);
  assign ctrlWr = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_WCTRL);
  assign cfgWr  = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_WCFG);
  assign stsWr  = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_WSTS);
  assign dbgWr  = wrAcc & isReg(avsReq.address, dwp_pkg::OFF_DBG);
  assign keyVal = avsReq.writedata[15:0];

  // independent watchdog timing: low-speed tick, divided by the prescaler
  assign iwFrozen  = debugHalt & st_q.dbgFreeze;
  assign iwTick    = lsiTick & ~iwFrozen;
  assign iwPreWrap = iwTick & (st_q.iwPre == iwDivLast(st_q.pscAct));
  assign iwStep    = iwPreWrap & st_q.iwRun;
  assign iwLoad    = keyWr & ((keyVal == dwp_pkg::KEY_RELOAD) |
                              ((keyVal == dwp_pkg::KEY_START) & ~st_q.iwRun));

  // window counter steps once every 2^tb bus clocks
  assign wwStep = (st_q.wwPre == 3'((4'h1 << st_q.wwTb) - 4'h1));

  // next state
  always_comb begin
    st_d        = st_q;
    st_d.sysRst = 1'b0;
    // one wait cycle per access; read data captured in the wait cycle
    st_d.busAck = (avsReq.read | avsReq.write) & ~st_q.busAck;
    if (avsReq.read & ~st_q.busAck) begin
      case (avsReq.address)
        dwp_pkg::OFF_KEY:   st_d.rdData = 32'h0000_0000;
        dwp_pkg::OFF_PSC:   st_d.rdData = {29'h0, st_q.pscSel};
        dwp_pkg::OFF_RLD:   st_d.rdData = {20'h0, st_q.rldSel};
        dwp_pkg::OFF_IWSTS: st_d.rdData = {30'h0, st_q.rldPend, st_q.pscPend};
        dwp_pkg::OFF_WCTRL: st_d.rdData = {24'h0, st_q.wwEn, st_q.wwCnt};
        dwp_pkg::OFF_WCFG:  st_d.rdData = {22'h0, st_q.early_warning_irq_enable, st_q.wwTb, st_q.wwWin};
        dwp_pkg::OFF_WSTS:  st_d.rdData = {31'h0, st_q.ewFlag};
        dwp_pkg::OFF_DBG:   st_d.rdData = {31'h0, st_q.dbgFreeze};
        default:            st_d.rdData = 32'h0000_0000;
      endcase
    end

    // key protection: only the unlock key opens, every other key closes
    if (keyWr) begin
      st_d.unlocked = (keyVal == dwp_pkg::KEY_UNLOCK);
      if (keyVal == dwp_pkg::KEY_START) begin
        st_d.iwRun = 1'b1;
      end
    end

    // hardware option caught once, on the first edge after release
    if (!st_q.hwCaught) begin
      st_d.hwCaught = 1'b1;
      if (hwWdgOpt) begin
        st_d.iwRun = 1'b1;
        st_d.iwCnt = st_q.rldAct;
      end
    end

    // prescaler and reload writes, accepted only unlocked and not pending
    if (pscWr & st_q.unlocked & ~st_q.pscPend) begin
      st_d.pscSel  = avsReq.writedata[2:0];
      st_d.pscPend = 1'b1;
    end else if (st_q.pscPend & lsiTick) begin
      st_d.pscAct  = st_q.pscSel;
      st_d.pscPend = 1'b0;
      st_d.iwPre   = 8'h00;
    end
    if (rldWr & st_q.unlocked & ~st_q.rldPend) begin
      st_d.rldSel  = avsReq.writedata[11:0];
      st_d.rldPend = 1'b1;
    end else if (st_q.rldPend & lsiTick) begin
      st_d.rldAct  = st_q.rldSel;
      st_d.rldPend = 1'b0;
    end

    // independent counter: load beats a step; no low-power gating, only a debug freeze stops it
    if (iwLoad) begin
      st_d.iwCnt = st_q.rldAct;
      if (keyVal == dwp_pkg::KEY_START) begin
        st_d.iwPre = 8'h00;
      end
    end else if (iwStep) begin
      if (st_q.iwCnt <= 12'h001) begin
        st_d.sysRst = 1'b1;
        st_d.iwCnt  = st_q.rldAct;
      end else begin
        st_d.iwCnt = st_q.iwCnt - 12'h001;
      end
    end
    if (st_q.iwRun & iwTick & ~(st_q.pscPend & lsiTick) & ~iwLoad) begin
      st_d.iwPre = iwPreWrap ? 8'h00 : st_q.iwPre + 8'h01;
    end

    // debug freeze select
    if (dbgWr) begin
      st_d.dbgFreeze = avsReq.writedata[0];
    end

    // window configuration
    if (cfgWr) begin
      st_d.wwWin = avsReq.writedata[6:0];
      st_d.wwTb  = avsReq.writedata[dwp_pkg::WCFG_TB_LSB +: 2];
      st_d.early_warning_irq_enable = avsReq.writedata[dwp_pkg::WCFG_EWI_BIT];
    end

    // flag clear goes first so that a same-cycle set wins
    if (stsWr & ~avsReq.writedata[0]) begin
      st_d.ewFlag = 1'b0;
    end

    // window prescaler counts every bus clock; a refresh restarts it from zero
    st_d.wwPre = wwStep ? 3'h0 : st_q.wwPre + 3'h1;

    // window counter: refresh or step; enable can only be set, reset clears it
    if (ctrlWr) begin
      if (avsReq.writedata[dwp_pkg::WCTRL_EN_BIT]) begin
        st_d.wwEn = 1'b1;
      end
      if (st_q.wwEn & (st_q.wwCnt > st_q.wwWin)) begin
        st_d.sysRst = 1'b1;
      end
      st_d.wwCnt = avsReq.writedata[6:0];
      st_d.wwPre = 3'h0;
    end else if (wwStep) begin
      st_d.wwCnt = st_q.wwCnt - 7'h01;
      if (st_q.wwEn & (st_q.wwCnt == dwp_pkg::WCNT_WARN)) begin
        st_d.sysRst = 1'b1;
      end
      if (st_q.early_warning_irq_enable & (st_q.wwCnt == dwp_pkg::WCNT_PREWARN)) begin
        st_d.ewFlag = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      st_q           <= '0;
      st_q.pscSel    <= dwp_pkg::PSC_RST;
      st_q.pscAct    <= dwp_pkg::PSC_RST;
      st_q.rldSel    <= dwp_pkg::RLD_RST;
      st_q.rldAct    <= dwp_pkg::RLD_RST;
      st_q.iwCnt     <= dwp_pkg::RLD_RST;
      st_q.wwCnt     <= dwp_pkg::WCNT_RST;
      st_q.wwWin     <= dwp_pkg::WWIN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  // outputs
  assign avsWaitrequest = (avsReq.read | avsReq.write) & ~st_q.busAck;
  assign avsReaddata    = st_q.rdData;
  assign sysResetReq    = st_q.sysRst;
  assign earlyWarnIrq   = st_q.ewFlag & st_q.early_warning_irq_enable;

  // checks
  default clocking dwpCb @(posedge mclk);
  endclocking
  default disable iff (!rstN);

  keyStart_a: assert property (keyWr && keyVal == dwp_pkg::KEY_START |=> st_q.iwRun)
    else $error("start key did not run the watchdog");
  iwZero_a: assert property (iwStep && !iwLoad && st_q.iwCnt <= 12'h001
                             |=> sysResetReq && st_q.iwCnt == $past(st_q.rldAct))
    else $error("no reset at independent count end");
  reloadKey_a: assert property (keyWr && keyVal == dwp_pkg::KEY_RELOAD
                                |=> st_q.iwCnt == $past(st_q.rldAct) && !st_q.unlocked)
    else $error("reload key did not reload and relock");
  lockedPsc_a: assert property (pscWr && !st_q.unlocked |=> $stable(st_q.pscSel))
    else $error("locked prescaler changed");
  relock_a: assert property (keyWr && keyVal != dwp_pkg::KEY_UNLOCK |=> !st_q.unlocked)
    else $error("protection not restored");
  hwStart_a: assert property (!st_q.hwCaught && hwWdgOpt |=> st_q.iwRun)
    else $error("hardware option did not start watchdog");
  dbgFreeze_a: assert property (iwFrozen && !keyWr && st_q.hwCaught
                                |=> $stable(st_q.iwCnt))
    else $error("counter moved while frozen");
  pscRange_a: assert property (st_q.iwPre <= iwDivLast(st_q.pscAct))
    else $error("prescaler beyond divider");
  wwUnder_a: assert property (wwStep && !ctrlWr && st_q.wwEn
                              && st_q.wwCnt == dwp_pkg::WCNT_WARN |=> sysResetReq)
    else $error("no reset on window underflow");
  earlyRef_a: assert property (ctrlWr && st_q.wwEn && st_q.wwCnt > st_q.wwWin
                               |=> sysResetReq)
    else $error("no reset on early refresh");
  wwEnHold_a: assert property (!st_q.wwEn && !(ctrlWr &&
                               avsReq.writedata[dwp_pkg::WCTRL_EN_BIT]) |=> !st_q.wwEn)
    else $error("window enabled without software");
  wwFree_a: assert property (wwStep && !ctrlWr |=>
                             st_q.wwCnt == 7'($past(st_q.wwCnt) - 7'h01))
    else $error("window counter did not step");
  ewSet_a: assert property (wwStep && !ctrlWr && st_q.early_warning_irq_enable
                            && st_q.wwCnt == dwp_pkg::WCNT_PREWARN |=> ##[0:1] earlyWarnIrq)
    else $error("early warning not raised");
  ewHold_a: assert property (st_q.ewFlag && !(stsWr && !avsReq.writedata[0])
                             |=> st_q.ewFlag)
    else $error("early warning flag lost");
  pscPend_a: assert property (st_q.pscPend && !lsiTick |=> st_q.pscPend)
    else $error("prescaler pending dropped early");
  rldPend_a: assert property (st_q.rldPend && !lsiTick |=> st_q.rldPend)
    else $error("reload pending dropped early");
  keyZero_a: assert property (avsReq.read && !st_q.busAck
                              && avsReq.address == dwp_pkg::OFF_KEY |=> avsReaddata == 32'h0)
    else $error("key register read not zero");

  iwReset_c: cover property (iwStep && st_q.iwCnt == 12'h001);
  wwRefresh_c: cover property (ctrlWr && st_q.wwEn && st_q.wwCnt <= st_q.wwWin);
  ewFlag_c: cover property (!st_q.ewFlag ##1 st_q.ewFlag);
  unlockWrite_c: cover property (st_q.unlocked && pscWr);

endmodule : dwp_watchdog

// File: dwp_tb_top.sv
// self-checking testbench for the dual watchdog pair
`timescale 1ns/1ps
module dwp_tb_top;
  // clock, reset, bus and watchdog environment
  logic                mclk      = 1'b0;
  logic                nrst      = 1'b0;
  logic                lsiTick   = 1'b0;
  logic                hwWdgOpt  = 1'b0;
  logic                debugHalt = 1'b0;
  dwp_pkg::dwp_avreq_s avsReq    = '0;
  logic                avsWaitrequest;
  logic [31:0]         avsReaddata;
  logic                sysResetReq;
  logic                earlyWarnIrq;
  int                  fails     = 0;
  int                  n_checks  = 0;
  int                  rstCnt    = 0;
  logic [31:0]         q;
  logic [6:0]          c0;
  int                  n;
  int                  n0;
  // reset rows: address beside the word it should read back (0x02 is unmapped)
  localparam logic [4:0]  R_ADDR [8] = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h14, 5'h18, 5'h1c, 5'h02};
  localparam logic [31:0] R_EXP  [8] = '{32'h0, {29'h0, dwp_pkg::PSC_RST},
    {20'h0, dwp_pkg::RLD_RST}, 32'h0, {25'h0, dwp_pkg::WWIN_RST}, 32'h0, 32'h0, 32'h0};

  dwp_watchdog u_dut (
    .mclk           (mclk),
    .nrst           (nrst),
    .avsReq         (avsReq),
    .avsWaitrequest (avsWaitrequest),
    .avsReaddata    (avsReaddata),
    .lsiTick        (lsiTick),
    .hwWdgOpt       (hwWdgOpt),
    .debugHalt      (debugHalt),
    .sysResetReq    (sysResetReq),
    .earlyWarnIrq   (earlyWarnIrq)
  );

  // 20 MHz clock
  always #25 mclk = ~mclk;

  // count reset pulses mid-cycle, where the one-cycle pulse is settled
  always @(negedge mclk) begin
    if (sysResetReq === 1'b1) begin
      rstCnt <= rstCnt + 1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : test_done

  // one avalon access; waitrequest and read data are taken at the rising edge itself,
  // before that edge's flop updates land, so the request stands where it is sampled
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int   k;
    logic ws;
    k  = 0;
    ws = 1'b1;
    @(posedge mclk);
    avsReq <= '{read: ~wr, write: wr, address: a, writedata: d, byteenable: 4'hf};
    while (ws !== 1'b0 && k < 20) begin
      @(posedge mclk);
      ws = avsWaitrequest;
      q  = avsReaddata;
      k++;
    end
    avsReq.read  <= 1'b0;
    avsReq.write <= 1'b0;
    if (ws !== 1'b0) begin
      fails++;
      test_done();
    end
  endtask : bus

  // pulse the slow tick until a reset shows or the bound runs out; four cycles per tick
  task automatic ticks(input int max, output int cnt);
    int base;
    base = rstCnt;
    cnt  = 0;
    while (rstCnt == base && cnt < max) begin
      @(posedge mclk);
      lsiTick <= 1'b1;
      cnt++;
      @(posedge mclk);
      lsiTick <= 1'b0;
      repeat (2) @(posedge mclk);
    end
  endtask : ticks

  // clock cycles from the current edge until a reset pulse is seen
  task automatic cyclesToRst(output int cnt);
    int base;
    base = rstCnt;
    cnt  = 0;
    while (rstCnt == base && cnt < 300) begin
      @(posedge mclk);
      cnt++;
    end
  endtask : cyclesToRst

  // main sequence: table rows first, then the hand-written cases
  initial begin : main
    int i;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    for (i = 0; i < 8; i++) begin
      bus(1'b0, R_ADDR[i], 32'h0);
      check(q, R_EXP[i]);
    end
    bus(1'b0, 5'h10, 32'h0);
    c0 = q[6:0];
    check({31'h0, q[7]}, 32'h0);
    bus(1'b0, 5'h10, 32'h0);
    check({25'h0, c0 - q[6:0]}, 32'h3);
    $display("test reset values done");
    // write protection and transfer flags
    bus(1'b1, 5'h04, 32'h1);
    bus(1'b0, 5'h04, 32'h0);
    check(q, 32'h0);
    bus(1'b1, 5'h00, 32'h5555);
    bus(1'b1, 5'h04, 32'h1);
    bus(1'b0, 5'h04, 32'h0);
    check(q, 32'h1);
    bus(1'b0, 5'h0c, 32'h0);
    check(q, 32'h1);
    ticks(1, n);
    bus(1'b0, 5'h0c, 32'h0);
    check(q, 32'h0);
    bus(1'b1, 5'h00, 32'h1234);
    bus(1'b1, 5'h08, 32'h5);
    bus(1'b0, 5'h08, 32'h0);
    check(q, 32'hfff);
    bus(1'b1, 5'h00, 32'h5555);
    bus(1'b1, 5'h00, 32'haaaa);
    bus(1'b1, 5'h08, 32'h5);
    bus(1'b0, 5'h08, 32'h0);
    check(q, 32'hfff);
    bus(1'b1, 5'h00, 32'h5555);
    bus(1'b1, 5'h08, 32'h2);
    bus(1'b0, 5'h0c, 32'h0);
    check(q, 32'h2);
    ticks(1, n);
    bus(1'b0, 5'h0c, 32'h0);
    check(q, 32'h0);
    $display("test protection done");
    // divide by 8, reload 2: a reset every 16 ticks
    bus(1'b1, 5'h00, 32'hcccc);
    ticks(40, n);
    check(n, 16);
    ticks(8, n);
    check(n, 8);
    bus(1'b1, 5'h00, 32'haaaa);
    ticks(40, n);
    check(n, 16);
    bus(1'b1, 5'h1c, 32'h1);
    debugHalt <= 1'b1;
    ticks(40, n);
    check(n, 40);
    debugHalt <= 1'b0;
    ticks(40, n);
    check(n, 16);
    bus(1'b1, 5'h1c, 32'h0);
    debugHalt <= 1'b1;
    ticks(40, n);
    check(n, 16);
    debugHalt <= 1'b0;
    $display("test independent watchdog done");
    // window watchdog: enable, warning flag, timeout scaling, early refresh
    bus(1'b1, 5'h10, 32'hff);
    bus(1'b1, 5'h14, 32'h27f);
    bus(1'b1, 5'h18, 32'h0);
    check({31'h0, earlyWarnIrq}, 32'h0);
    bus(1'b1, 5'h10, 32'hc5);
    cyclesToRst(n0);
    check(32'(n0 >= 6 && n0 <= 8), 32'h1);
    check({31'h0, earlyWarnIrq}, 32'h1);
    bus(1'b1, 5'h18, 32'h1);
    @(negedge mclk);
    check({31'h0, earlyWarnIrq}, 32'h1);
    bus(1'b1, 5'h18, 32'h0);
    @(negedge mclk);
    check({31'h0, earlyWarnIrq}, 32'h0);
    bus(1'b1, 5'h14, 32'h2ff);
    bus(1'b1, 5'h10, 32'hc5);
    cyclesToRst(n);
    check(n - n0, 32'h6);
    bus(1'b1, 5'h14, 32'h27f);
    bus(1'b1, 5'h10, 32'hff);
    bus(1'b1, 5'h14, 32'h250);
    n0 = rstCnt;
    bus(1'b1, 5'h10, 32'hff);
    repeat (2) @(posedge mclk);
    check(rstCnt - n0, 32'h1);
    $display("test window watchdog done");
    // hardware option: runs from reset at divide 4 and full reload, window off again
    hwWdgOpt <= 1'b1;
    nrst     <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (4) @(posedge mclk);
    ticks(20000, n);
    check(n, 16380);
    $display("test hardware option done");
    test_done();
  end

endmodule : dwp_tb_top
